// *** bst_pkg.sv ***
/*
  Package for the boundary-scan test port: opcodes, state encoding,
  register widths and synchroniser depth.
  Assumes a single system clock that oversamples the test clock.
*/
package bst_pkg;

  // =====================================================
  // Instruction register
  // =====================================================
  localparam int          IR_W          = 6;
  localparam logic [5:0]  OP_BYPASS     = 6'h3F;
  localparam logic [5:0]  OP_SAMPLE     = 6'h04;
  localparam logic [5:0]  OP_EXTEST     = 6'h01;
  localparam logic [5:0]  OP_HIGHZ      = 6'h03;
  localparam logic [5:0]  OP_IDCODE     = 6'h0A;
  localparam logic [5:0]  IR_CAPTURE    = 6'h01;

  // =====================================================
  // Data registers and synchroniser depth
  // =====================================================
  localparam int          ID_W          = 32;
  // Arbitrary identity value, not a real maker code
  localparam logic [31:0] ID_VALUE_DEF  = 32'h0ABC_D001;
  localparam int          BSR_W         = 16;
  localparam int          SYNC_W        = 2;

  // =====================================================
  // Test-port controller states
  // =====================================================
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
    ST_PA_IR, ST_EX2_IR, ST_UPD_IR
  } bst_state_t;

endpackage

// *** bst_sync.sv ***
/*
  Two-flop synchroniser for the test-port pins.
  Assumes asynchronous inputs and the system clock domain.
*/
`timescale 1ns/1ps
module bst_sync
  import bst_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule // bst_sync

// *** bst_tap.sv ***
/*
  Boundary-scan test access port: controller, instruction register,
  bypass, identity and boundary register, and pin muxing.
  Assumes clk is much faster than the test clock (at least 4x) and that
  resetn is the chip power-on reset.
*/
// Function
// - Five pins: clock, select, in, out, reset
// - State machine, instruction and data registers
// - Sample select and input on rising edge
// - Update serial output on falling edge
// - Reset by power-on or test reset low
// - Decode bypass, sample/preload, extest opcodes
// - Highz floats outputs, selects bypass path
// - Idcode shifts identity out
// - Identity value fixed and hard-wired
// - Digital pins scanned; analog, crystal excluded
`timescale 1ns/1ps
module bst_tap
  import bst_pkg::*;
#(
  parameter logic [ID_W-1:0] ID_VALUE = ID_VALUE_DEF
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             tck,
  input  wire logic             tms,
  input  wire logic             tdi,
  input  wire logic             trst_n,
  output logic                  tdo,
  output logic                  tdo_oe_n,
  input  wire logic [BSR_W-1:0] core_out,
  input  wire logic [BSR_W-1:0] core_oe_n,
  input  wire logic [BSR_W-1:0] pin_in,
  output logic      [BSR_W-1:0] pin_out,
  output logic      [BSR_W-1:0] pin_oe_n,
  output logic      [BSR_W-1:0] core_in
);

  // =====================================================
  // Pin synchronisers
  // =====================================================
  logic [3:0]       pins_s;
  logic [BSR_W-1:0] pin_in_s;
  logic             tck_s;
  logic             tms_s;
  logic             tdi_s;
  logic             trst_n_s;

  bst_sync #(.W(4)) u_sync_jtag (
    .clk     (clk),
    .resetn  (resetn),
    .async_i ({tck, tms, tdi, trst_n}),
    .sync_o  (pins_s)
  );

  bst_sync #(.W(BSR_W)) u_sync_pins (
    .clk     (clk),
    .resetn  (resetn),
    .async_i (pin_in),
    .sync_o  (pin_in_s)
  );

  assign {tck_s, tms_s, tdi_s, trst_n_s} = pins_s;

  // =====================================================
  // State registers
  // =====================================================
  bst_state_t       st_q,     st_d;
  logic             tck_q,    tck_d;
  logic [IR_W-1:0]  irsh_q,   irsh_d;
  logic [IR_W-1:0]  ir_q,     ir_d;
  logic             byp_q,    byp_d;
  logic [ID_W-1:0]  idsh_q,   idsh_d;
  logic [BSR_W-1:0] bsh_q,    bsh_d;
  logic [BSR_W-1:0] bupd_q,   bupd_d;
  logic             tdo_q,    tdo_d;
  logic             tdooe_q,  tdooe_d;
  logic [BSR_W-1:0] pout_q,   pout_d;
  logic [BSR_W-1:0] poe_q,    poe_d;
  logic [BSR_W-1:0] cin_q,    cin_d;

  logic rise;
  logic fall;
  logic sel_bsr;
  logic sel_id;
  logic drive_bsr;
  logic float_all;

  assign rise = tck_s & ~tck_q;
  assign fall = ~tck_s & tck_q;

  always_comb begin
    sel_bsr   = 1'b0;
    sel_id    = 1'b0;
    drive_bsr = 1'b0;
    float_all = 1'b0;
    case (ir_q)
      OP_SAMPLE: sel_bsr = 1'b1;
      OP_EXTEST: begin
        sel_bsr   = 1'b1;
        drive_bsr = 1'b1;
      end
      OP_HIGHZ:  float_all = 1'b1;
      OP_IDCODE: sel_id = 1'b1;
      default:   ;
    endcase
  end

  // =====================================================
  // Controller, registers, next state
  // =====================================================
  always_comb begin
    st_d    = st_q;
    tck_d   = tck_s;
    irsh_d  = irsh_q;
    ir_d    = ir_q;
    byp_d   = byp_q;
    idsh_d  = idsh_q;
    bsh_d   = bsh_q;
    bupd_d  = bupd_q;
    tdo_d   = tdo_q;
    tdooe_d = tdooe_q;

    if (rise) begin
      case (st_q)
        ST_RESET:  st_d = tms_s ? ST_RESET  : ST_IDLE;
        ST_IDLE:   st_d = tms_s ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: st_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: st_d = tms_s ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR:  st_d = tms_s ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: st_d = tms_s ? ST_UPD_DR : ST_PA_DR;
        ST_PA_DR:  st_d = tms_s ? ST_EX2_DR : ST_PA_DR;
        ST_EX2_DR: st_d = tms_s ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: st_d = tms_s ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: st_d = tms_s ? ST_RESET  : ST_CAP_IR;
        ST_CAP_IR: st_d = tms_s ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR:  st_d = tms_s ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: st_d = tms_s ? ST_UPD_IR : ST_PA_IR;
        ST_PA_IR:  st_d = tms_s ? ST_EX2_IR : ST_PA_IR;
        ST_EX2_IR: st_d = tms_s ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: st_d = tms_s ? ST_SEL_DR : ST_IDLE;
        default:   st_d = ST_RESET;
      endcase

      // capture and shift of selected register
      case (st_q)
        ST_CAP_IR: irsh_d = IR_CAPTURE;
        ST_SH_IR:  irsh_d = {tdi_s, irsh_q[IR_W-1:1]};
        ST_CAP_DR: begin
          byp_d = 1'b0;
          if (sel_id) idsh_d = ID_VALUE;
          if (sel_bsr) bsh_d = pin_in_s;
        end
        ST_SH_DR: begin
          byp_d = tdi_s;
          if (sel_id) idsh_d = {tdi_s, idsh_q[ID_W-1:1]};
          if (sel_bsr) bsh_d = {tdi_s, bsh_q[BSR_W-1:1]};
        end
        default: ;
      endcase
    end

    // Update stages act on the falling edge after entry
    if (fall) begin
      if (st_q == ST_UPD_IR) ir_d = irsh_q;
      if (st_q == ST_UPD_DR && sel_bsr) bupd_d = bsh_q;
      // serial output changes on falling edge
      tdooe_d = ~(st_q == ST_SH_DR || st_q == ST_SH_IR);
      if (st_q == ST_SH_IR) tdo_d = irsh_q[0];
      else if (sel_id) tdo_d = idsh_q[0];
      else if (sel_bsr) tdo_d = bsh_q[0];
      else tdo_d = byp_q;
    end

    if (st_q == ST_RESET) ir_d = OP_IDCODE;
  end

  always_comb begin
    pout_d = drive_bsr ? bupd_q : core_out;
    poe_d  = float_all ? {BSR_W{1'b1}} : (drive_bsr ? {BSR_W{1'b0}} : core_oe_n);
    cin_d  = pin_in_s;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q    <= ST_RESET;
      ir_q    <= OP_IDCODE;
      irsh_q  <= '0;
      byp_q   <= 1'b0;
      idsh_q  <= '0;
      bsh_q   <= '0;
      bupd_q  <= '0;
      tdo_q   <= 1'b0;
      tdooe_q <= 1'b1;
    end else if (!trst_n_s) begin
      st_q    <= ST_RESET;
      ir_q    <= OP_IDCODE;
      irsh_q  <= '0;
      byp_q   <= 1'b0;
      idsh_q  <= '0;
      bsh_q   <= '0;
      bupd_q  <= '0;
      tdo_q   <= 1'b0;
      tdooe_q <= 1'b1;
    end else begin
      st_q    <= st_d;
      ir_q    <= ir_d;
      irsh_q  <= irsh_d;
      byp_q   <= byp_d;
      idsh_q  <= idsh_d;
      bsh_q   <= bsh_d;
      bupd_q  <= bupd_d;
      tdo_q   <= tdo_d;
      tdooe_q <= tdooe_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tck_q  <= 1'b0;
      pout_q <= '0;
      poe_q  <= '1;
      cin_q  <= '0;
    end else begin
      tck_q  <= tck_d;
      pout_q <= pout_d;
      poe_q  <= poe_d;
      cin_q  <= cin_d;
    end
  end

  assign tdo      = tdo_q;
  assign tdo_oe_n = tdooe_q;
  assign pin_out  = pout_q;
  assign pin_oe_n = poe_q;
  assign core_in  = cin_q;

endmodule // bst_tap

// *** bst_tap_properties.sv ***
/* Port timing checks for bst_tap, bound to every instance.
   Assumes tck phases of at least 4 clk. */
`timescale 1ns/1ps
module bst_tap_chk
  import bst_pkg::*;
(
  input wire logic             clk,
  input wire logic             resetn,
  input wire logic             tck,
  input wire logic             trst_n,
  input wire logic             tdo,
  input wire logic             tdo_oe_n,
  input wire logic [BSR_W-1:0] core_out,
  input wire logic [BSR_W-1:0] core_oe_n,
  input wire logic [BSR_W-1:0] pin_in,
  input wire logic [BSR_W-1:0] pin_out,
  input wire logic [BSR_W-1:0] pin_oe_n,
  input wire logic [BSR_W-1:0] core_in
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ========
  // Sequences
  sequence s_tck_low;
    !$past(tck, 1) && !$past(tck, 3);
  endsequence
  sequence s_trst_held;
    !trst_n [*5];
  endsequence
  sequence s_pin_settled;
    $stable(pin_in) [*4] ##0 $past(resetn, 4);
  endsequence
  // ========
  // Properties
  property p_rst_idle;
    $rose(resetn) |-> tdo_oe_n && (tdo == 1'b0) && (pin_oe_n == '1);
  endproperty
  property p_tdo_fall;
    $changed(tdo) |-> s_tck_low;
  endproperty
  property p_trst;
    s_trst_held |=> tdo_oe_n && (tdo == 1'b0);
  endproperty
  property p_trst_pins;
    s_trst_held |=> pin_oe_n == $past(core_oe_n);
  endproperty
  property p_oe_chg;
    $changed(pin_oe_n) |-> ($past(core_oe_n) != $past(core_oe_n, 2)) || !$past(resetn, 2)
      || (!$past(tck) && !$past(tck, 3));
  endproperty
  property p_out_chg;
    $changed(pin_out) |-> ($past(core_out) != $past(core_out, 2)) || !$past(resetn, 2)
      || (!$past(tck) && !$past(tck, 3));
  endproperty
  property p_core_in;
    s_pin_settled |-> core_in == pin_in;
  endproperty
  property p_oe_modes;
    (pin_oe_n == '1) || (pin_oe_n == '0) || (pin_oe_n == $past(core_oe_n));
  endproperty
  a_rst_idle:  assert property (p_rst_idle)  else $error("tap not idle after reset");
  a_tdo_fall:  assert property (p_tdo_fall)  else $error("tdo moved off a tck fall");
  a_trst:      assert property (p_trst)      else $error("test reset left tdo on");
  a_trst_pins: assert property (p_trst_pins) else $error("pins not functional");
  a_oe_chg:    assert property (p_oe_chg)    else $error("pin enable moved unasked");
  a_out_chg:   assert property (p_out_chg)   else $error("pin value moved unasked");
  a_core_in:   assert property (p_core_in)   else $error("core input wrong");
  a_oe_modes:  assert property (p_oe_modes)  else $error("pin enable mode wrong");
endmodule // bst_tap_chk

bind bst_tap bst_tap_chk u_chk (.clk(clk), .resetn(resetn), .tck(tck), .trst_n(trst_n), .tdo(tdo),
  .tdo_oe_n(tdo_oe_n), .core_out(core_out), .core_oe_n(core_oe_n), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .core_in(core_in));

// *** bst_tester.sv ***
/* Test controller model on the five test pins.
   Assumes clk at 50 MHz; tck stands low between scans. */
`timescale 1ns/1ps
module bst_tester (
  input  wire logic clk,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end
  // Drive on fall, sample tdo late
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    repeat (4) @(posedge clk);
    #1 tck = 1'b1;
    repeat (4) @(posedge clk);
    #1 o = tdo;
    tck = 1'b0;
  endtask
  // Idle to idle scan, LSB first
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic o;
    dout = '0;
    tick(1'b1, 1'b0, o);
    if (ir) tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
  endtask
  task automatic pulse_trst();
    logic o;
    trst_n = 1'b0;
    repeat (10) @(posedge clk);
    #1 trst_n = 1'b1;
    repeat (6) @(posedge clk);
    #1 tick(1'b0, 1'b0, o);
  endtask
endmodule // bst_tester

// *** tb_top.sv ***
/* Self-checking bench for bst_tap.
   Assumes bst_tester and the checker are compiled first. */
`timescale 1ns/1ps
module tb_top;
  import bst_pkg::*;
  typedef struct packed {
    logic [5:0]  op;
    logic [1:0]  oe;
    logic [5:0]  len;
    logic [31:0] exp;
  } bst_row_t;
  localparam logic [31:0] DIN = 32'h0000_C35A;
  logic             clk, resetn, tck, tms, tdi, trst_n, tdo, tdo_oe_n, o;
  logic [BSR_W-1:0] core_out, core_oe_n, pin_in, pin_out, pin_oe_n, core_in, eo;
  logic [31:0]      dout;
  int               error_cnt, compares, cyc;
  bst_row_t rows [6] = '{'{OP_SAMPLE, 2'h0, 6'h10, 32'h6C93}, '{OP_EXTEST, 2'h2, 6'h10, 32'h6C93},
    '{OP_BYPASS, 2'h0, 6'h08, 32'hB4}, '{OP_HIGHZ, 2'h1, 6'h08, 32'hB4},
    '{6'h2A, 2'h0, 6'h08, 32'hB4}, '{OP_IDCODE, 2'h0, 6'h20, ID_VALUE_DEF}};
  bst_tap uut (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n), .core_out(core_out), .core_oe_n(core_oe_n), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .core_in(core_in));
  bst_tester tst (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    core_out = 16'h1234;
    core_oe_n = 16'h00FF;
    pin_in = 16'h6C93;
    repeat (3) @(posedge clk);
    #1 resetn = 1'b1;
    core_oe_n = 16'hF0F0;
    repeat (6) @(posedge clk);
    #1;
    chk("tdo_oe_n", {31'h0, tdo_oe_n}, 32'h1);
    chk("pin_oe_n", {16'h0, pin_oe_n}, 32'hF0F0);
    #1 tst.tick(1'b0, 1'b0, o);
    foreach (rows[i]) begin
      tst.scan(1'b1, 6, {26'h0, rows[i].op}, dout);
      chk("ir_capture", dout, 32'h1);
      repeat (6) @(posedge clk);
      #1;
      eo = rows[i].oe == 2'h1 ? 16'hFFFF : rows[i].oe == 2'h2 ? 16'h0 : core_oe_n;
      chk("pin_oe_n", {16'h0, pin_oe_n}, {16'h0, eo});
      if (rows[i].oe != 2'h1) begin
        chk("pin_out", {16'h0, pin_out}, rows[i].oe[1] ? DIN : {16'h0, core_out});
      end
      #1 tst.scan(1'b0, rows[i].len, DIN, dout);
      chk("dr_out", dout, rows[i].exp);
    end
    tst.scan(1'b1, 6, {26'h0, OP_EXTEST}, dout);
    tst.pulse_trst();
    chk("pin_oe_n", {16'h0, pin_oe_n}, {16'h0, core_oe_n});
    tst.scan(1'b0, 32, DIN, dout);
    chk("id_after_trst", dout, ID_VALUE_DEF);
    test_done();
  end
endmodule // tb_top
